// *** logic/typec_pkg.sv ***
// Constants and types shared by the Type-C source port control logic.
package typec_pkg;
    // System clock rate.
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_MHZ = CLK_HZ / 1_000_000;
    // Settling time of a CC line level before it counts, in microseconds.
    localparam int DEBOUNCE_US = 150;
    localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
    // Time the VBUS discharge path stays on after a detach, in microseconds.
    localparam int DISCHARGE_US = 1000;
    localparam int DISCHARGE_CYC = DISCHARGE_US * CLK_MHZ;
    // Level seen on a CC line by its comparators.
    localparam logic [1:0] CC_OPEN = 2'h0;
    localparam logic [1:0] CC_RD = 2'h1;
    localparam logic [1:0] CC_RA = 2'h2;
    // Pull-up current advertised on a CC line.
    localparam logic [1:0] RP_OFF = 2'h0;
    localparam logic [1:0] RP_DEFAULT = 2'h1;
    localparam logic [1:0] RP_1A5 = 2'h2;
    localparam logic [1:0] RP_3A0 = 2'h3;
    // Register byte addresses.
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_IRQ_CLEAR = 8'h04;
    localparam logic [7:0] REG_IRQ_ENABLE = 8'h08;
    localparam logic [7:0] REG_PORT_STATE = 8'h0c;
    localparam logic [7:0] REG_CONTROL = 8'h10;
    // Event bits of the status, clear and enable registers.
    localparam int EV_W = 4;
    localparam int EV_ATTACH = 0;
    localparam int EV_DETACH = 1;
    localparam int EV_OVERLOAD = 2;
    localparam int EV_HEAVY = 3;
    localparam logic [EV_W-1:0] IRQ_ENABLE_RESET = 4'h0;
    // Control register.
    localparam int CTRL_ENABLE_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    // Open-drain status pin indices.
    localparam int OD_W = 6;
    localparam int OD_SINK = 0;
    localparam int OD_HEADSET = 1;
    localparam int OD_TEST_ACC = 2;
    localparam int OD_ORIENT = 3;
    localparam int OD_OVERLOAD = 4;
    localparam int OD_HEAVY = 5;
    // Port state register fields.
    localparam int PS_STATE_LSB = 0;
    localparam int PS_ORIENT_BIT = 4;
    localparam int PS_EMARK_BIT = 5;
    localparam int PS_CURRENT_LIMIT_STRAP_BIT = 6;
    localparam int PS_PIN_LSB = 8;
    localparam int PS_RP1_LSB = 16;
    localparam int PS_RP2_LSB = 18;
    typedef enum logic [2:0] {
        ST_UNATTACHED,
        ST_SINK,
        ST_AUDIO,
        ST_DEBUG,
        ST_DISCHARGE
    } port_state_type;
endpackage

// *** logic/event_irq_if.sv ***
// Interface carrying port events, their clears and mask to the status keeper.
`timescale 1ns/100ps
`default_nettype none
interface event_irq_if;
    logic [typec_pkg::EV_W-1:0] raise;
    logic [typec_pkg::EV_W-1:0] clear;
    logic [typec_pkg::EV_W-1:0] mask;
    logic [typec_pkg::EV_W-1:0] status;
    logic                       irq;
    modport owner (output raise, output clear, output mask, input status, input irq);
    modport keeper (input raise, input clear, input mask, output status, output irq);
endinterface
`default_nettype wire

// *** logic/event_status.sv ***
// Sticky event status bits with write-one-to-clear and a masked interrupt.
`timescale 1ns/100ps
`default_nettype none
module event_status (
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   rst_n,
    // Events, clears, mask and results
    event_irq_if.keeper ev
);
    logic [typec_pkg::EV_W-1:0] status_q;
    logic [typec_pkg::EV_W-1:0] status_d;

    // A new event in the clearing cycle survives, so none is lost.
    assign status_d = (status_q & ~ev.clear) | ev.raise;
    assign ev.status = status_q;
    assign ev.irq = |(status_q & ev.mask);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status_q <= '0;
        end else begin
            status_q <= status_d;
        end
    end
endmodule
`default_nettype wire

// *** logic/cc_filter.sv ***
// Debounce of one CC line level: a level counts once it held for CYCLES clocks.
`timescale 1ns/100ps
`default_nettype none
module cc_filter #(
    parameter int CYCLES = typec_pkg::DEBOUNCE_CYC
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Raw and settled line level
    input  wire logic [1:0] raw,
    output logic [1:0]      stable_q
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [1:0]    cand_q;
    logic [CW-1:0] cnt_q;
    wire           moved = raw != cand_q;
    wire           held = cnt_q == LAST;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cand_q <= typec_pkg::CC_OPEN;
            cnt_q <= '0;
            stable_q <= typec_pkg::CC_OPEN;
        end else if (moved) begin
            cand_q <= raw;
            cnt_q <= '0;
        end else if (held) begin
            stable_q <= cand_q;
        end else begin
            cnt_q <= cnt_q + CW'(1);
        end
    end
endmodule
`default_nettype wire

// *** logic/typec_source_port_control.sv ***
// Control logic of a USB Type-C downstream-facing source port.
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module typec_source_port_control #(
    parameter int DISCHARGE_CYC = typec_pkg::DISCHARGE_CYC,
    parameter int DEBOUNCE_CYC  = typec_pkg::DEBOUNCE_CYC
) (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    // Control pins
    input  wire logic                      enable,
    input  wire logic                      charge_select,
    input  wire logic                      charge_high_select,
    input  wire logic                      current_limit_strap,
    // CC line levels from the line comparators
    input  wire logic [1:0]                cc1_level,
    input  wire logic [1:0]                cc2_level,
    // Power switch monitors
    input  wire logic                      switch_current_limiting,
    input  wire logic                      switch_over_temp,
    input  wire logic                      load_above_heavy,
    // Power path controls
    output logic                           bus_power_switch_on,
    output logic                           vbus_discharge_on,
    output logic                           cable_power_to_cc1,
    output logic                           cable_power_to_cc2,
    output logic                           current_limit_high,
    // CC pull-up advertisement
    output logic [1:0]                     cc1_rp_level,
    output logic [1:0]                     cc2_rp_level,
    // Open-drain status pins
    input  wire logic [typec_pkg::OD_W-1:0] status_pin_in,
    output logic [typec_pkg::OD_W-1:0]     status_pin_out,
    output logic [typec_pkg::OD_W-1:0]     status_pin_oe_n,
    // Register port
    input  wire logic [7:0]                reg_addr,
    input  wire logic [31:0]               reg_wdata,
    input  wire logic                      reg_write,
    input  wire logic                      reg_read,
    output logic [31:0]                    reg_rdata,
    // Interrupt
    output logic                           irq
);
    localparam int DW = $clog2(DISCHARGE_CYC + 1);
    localparam logic [DW-1:0] DIS_LAST = DW'(DISCHARGE_CYC - 1);
    localparam int EW = typec_pkg::EV_W;
    localparam int PW = typec_pkg::OD_W;

    function automatic logic is_rd(input logic [1:0] level);
        return level == typec_pkg::CC_RD;
    endfunction

    function automatic logic is_ra(input logic [1:0] level);
        return level == typec_pkg::CC_RA;
    endfunction

    // Raw and settled CC levels, index 0 for CC1 and 1 for CC2.
    logic [1:0] cc_raw [2];
    logic [1:0] cc_flt [2];

    // Port state.
    typec_pkg::port_state_type state_q;
    typec_pkg::port_state_type state_d;
    logic                      orient_q;
    logic                      orient_d;
    logic                      emark_q;
    logic                      emark_d;
    logic [DW-1:0]             dis_cnt_q;
    logic [DW-1:0]             dis_cnt_d;
    logic                      attach_ev;
    logic                      detach_ev;

    // Strap capture.
    logic                      strap_done_q;
    logic                      current_limit_strap_q;

    // Output registers.
    logic                      vbus_q;
    logic                      discharge_q;
    logic                      vconn1_q;
    logic                      vconn2_q;
    logic [1:0]                rp1_q;
    logic [1:0]                rp2_q;
    logic [PW-1:0]             pin_q;
    logic [PW-1:0]             pin_d;

    // Software registers.
    logic [31:0]               ctrl_q;
    logic [EW-1:0]             irq_en_q;
    logic [31:0]               rdata_q;
    logic [31:0]               port_word;

    event_irq_if ev ();

    assign cc_raw[0] = cc1_level;
    assign cc_raw[1] = cc2_level;

    for (genvar i = 0; i < 2; i++) begin : g_cc
        cc_filter #(
            .CYCLES (DEBOUNCE_CYC)
        ) u_filter (
            .clk      (clk),
            .rst_n    (rst_n),
            .raw      (cc_raw[i]),
            .stable_q (cc_flt[i])
        );
    end

    // Classification of the settled line levels.
    wire rd1 = is_rd(cc_flt[0]);
    wire rd2 = is_rd(cc_flt[1]);
    wire ra1 = is_ra(cc_flt[0]);
    wire ra2 = is_ra(cc_flt[1]);
    wire cls_debug = rd1 & rd2;
    wire cls_audio = ra1 & ra2;
    wire cls_sink = rd1 ^ rd2;
    wire cls_emark = (rd1 & ra2) | (rd2 & ra1);
    wire sink_still = orient_q ? rd2 : rd1;

    wire port_on = enable & ctrl_q[typec_pkg::CTRL_ENABLE_BIT];

    always_comb begin
        state_d = state_q;
        orient_d = orient_q;
        emark_d = emark_q;
        dis_cnt_d = dis_cnt_q;
        attach_ev = 1'b0;
        detach_ev = 1'b0;
        unique case (state_q)
            typec_pkg::ST_UNATTACHED: begin
                if (port_on && cls_debug) begin
                    state_d = typec_pkg::ST_DEBUG;
                    attach_ev = 1'b1;
                end else if (port_on && cls_audio) begin
                    state_d = typec_pkg::ST_AUDIO;
                    attach_ev = 1'b1;
                end else if (port_on && cls_sink) begin
                    state_d = typec_pkg::ST_SINK;
                    orient_d = rd2;
                    emark_d = cls_emark;
                    attach_ev = 1'b1;
                end
            end
            typec_pkg::ST_SINK: begin
                if (!port_on || !sink_still) begin
                    state_d = typec_pkg::ST_DISCHARGE;
                    orient_d = 1'b0;
                    emark_d = 1'b0;
                    dis_cnt_d = '0;
                    detach_ev = 1'b1;
                end
            end
            typec_pkg::ST_AUDIO: begin
                if (!port_on || !cls_audio) begin
                    state_d = typec_pkg::ST_UNATTACHED;
                    detach_ev = 1'b1;
                end
            end
            typec_pkg::ST_DEBUG: begin
                if (!port_on || !cls_debug) begin
                    state_d = typec_pkg::ST_UNATTACHED;
                    detach_ev = 1'b1;
                end
            end
            typec_pkg::ST_DISCHARGE: begin
                // The port stays deaf until VBUS had time to bleed down.
                if (dis_cnt_q == DIS_LAST) begin
                    state_d = typec_pkg::ST_UNATTACHED;
                end else begin
                    dis_cnt_d = dis_cnt_q + DW'(1);
                end
            end
            default: begin
                state_d = typec_pkg::ST_UNATTACHED;
                orient_d = 1'b0;
                emark_d = 1'b0;
            end
        endcase
    end

    // Output values for the state being entered.
    wire in_sink = state_d == typec_pkg::ST_SINK;
    wire rp_both = port_on & (state_d != typec_pkg::ST_SINK) & (state_d != typec_pkg::ST_DISCHARGE);

    // high level only in Type-C mode
    wire [1:0] adv_level = !charge_select ? typec_pkg::RP_DEFAULT
                         : charge_high_select ? typec_pkg::RP_3A0 : typec_pkg::RP_1A5;

    wire [1:0] rp1_d = (rp_both | (in_sink & !orient_d)) ? adv_level : typec_pkg::RP_OFF;
    wire [1:0] rp2_d = (rp_both | (in_sink & orient_d)) ? adv_level : typec_pkg::RP_OFF;

    wire vconn1_d = in_sink & emark_d & orient_d;
    wire vconn2_d = in_sink & emark_d & !orient_d;

    wire overload = switch_current_limiting | switch_over_temp;

    wire heavy = in_sink & (adv_level == typec_pkg::RP_3A0) & load_above_heavy;

    always_comb begin
        pin_d = '0;
        pin_d[typec_pkg::OD_SINK] = in_sink;
        pin_d[typec_pkg::OD_HEADSET] = state_d == typec_pkg::ST_AUDIO;
        pin_d[typec_pkg::OD_TEST_ACC] = state_d == typec_pkg::ST_DEBUG;
        pin_d[typec_pkg::OD_ORIENT] = in_sink & orient_d;
        pin_d[typec_pkg::OD_OVERLOAD] = overload;
        pin_d[typec_pkg::OD_HEAVY] = heavy;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= typec_pkg::ST_UNATTACHED;
            orient_q <= 1'b0;
            emark_q <= 1'b0;
            dis_cnt_q <= '0;
        end else begin
            state_q <= state_d;
            orient_q <= orient_d;
            emark_q <= emark_d;
            dis_cnt_q <= dis_cnt_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            vbus_q <= 1'b0;
            discharge_q <= 1'b0;
            vconn1_q <= 1'b0;
            vconn2_q <= 1'b0;
            rp1_q <= typec_pkg::RP_OFF;
            rp2_q <= typec_pkg::RP_OFF;
            pin_q <= '0;
        end else begin
            vbus_q <= in_sink;
            discharge_q <= state_d == typec_pkg::ST_DISCHARGE;
            vconn1_q <= vconn1_d;
            vconn2_q <= vconn2_d;
            rp1_q <= rp1_d;
            rp2_q <= rp2_d;
            pin_q <= pin_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            strap_done_q <= 1'b0;
            current_limit_strap_q <= 1'b0;
        end else if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            current_limit_strap_q <= current_limit_strap;
        end
    end

    // Register decode.
    wire wr_clear = reg_write & (reg_addr == typec_pkg::REG_IRQ_CLEAR);
    wire wr_enable = reg_write & (reg_addr == typec_pkg::REG_IRQ_ENABLE);
    wire wr_ctrl = reg_write & (reg_addr == typec_pkg::REG_CONTROL);

    // Events rise on edges, so a lasting fault raises one interrupt only.
    assign ev.raise[typec_pkg::EV_ATTACH] = attach_ev;
    assign ev.raise[typec_pkg::EV_DETACH] = detach_ev;
    assign ev.raise[typec_pkg::EV_OVERLOAD] = pin_d[typec_pkg::OD_OVERLOAD] & ~pin_q[typec_pkg::OD_OVERLOAD];
    assign ev.raise[typec_pkg::EV_HEAVY] = pin_d[typec_pkg::OD_HEAVY] & ~pin_q[typec_pkg::OD_HEAVY];
    assign ev.clear = wr_clear ? reg_wdata[EW-1:0] : '0;
    assign ev.mask = irq_en_q;

    event_status u_status (
        .clk   (clk),
        .rst_n (rst_n),
        .ev    (ev.keeper)
    );

    always_comb begin
        port_word = '0;
        port_word[typec_pkg::PS_STATE_LSB +: 3] = state_q;
        port_word[typec_pkg::PS_ORIENT_BIT] = orient_q;
        port_word[typec_pkg::PS_EMARK_BIT] = emark_q;
        port_word[typec_pkg::PS_CURRENT_LIMIT_STRAP_BIT] = current_limit_strap_q;
        port_word[typec_pkg::PS_PIN_LSB +: PW] = status_pin_in;
        port_word[typec_pkg::PS_RP1_LSB +: 2] = rp1_q;
        port_word[typec_pkg::PS_RP2_LSB +: 2] = rp2_q;
    end

    // Write-only and unmapped addresses read as zero.
    wire [31:0] rd_mux = (reg_addr == typec_pkg::REG_STATUS) ? {{(32 - EW){1'b0}}, ev.status}
                       : (reg_addr == typec_pkg::REG_IRQ_ENABLE) ? {{(32 - EW){1'b0}}, irq_en_q}
                       : (reg_addr == typec_pkg::REG_PORT_STATE) ? port_word
                       : (reg_addr == typec_pkg::REG_CONTROL) ? ctrl_q : 32'h0000_0000;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_q <= typec_pkg::CTRL_RESET;
            irq_en_q <= typec_pkg::IRQ_ENABLE_RESET;
            rdata_q <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= {31'h0000_0000, reg_wdata[typec_pkg::CTRL_ENABLE_BIT]};
            end
            if (wr_enable) begin
                irq_en_q <= reg_wdata[EW-1:0];
            end
            rdata_q <= reg_read ? rd_mux : '0;
        end
    end

    assign status_pin_out = '0;
    assign status_pin_oe_n = ~pin_q;

    assign bus_power_switch_on = vbus_q;
    assign vbus_discharge_on = discharge_q;
    assign cable_power_to_cc1 = vconn1_q;
    assign cable_power_to_cc2 = vconn2_q;
    assign current_limit_high = current_limit_strap_q;
    assign cc1_rp_level = rp1_q;
    assign cc2_rp_level = rp2_q;
    assign reg_rdata = rdata_q;
    assign irq = ev.irq;
endmodule
`default_nettype wire

// *** sim/cc_partner.sv ***
// Model of the party at the receptacle: a sink, a marked cable or an accessory.
`timescale 1ns/100ps
`default_nettype none
module cc_partner (
    // Kind of party attached, 0 for none
    input  wire logic [2:0] mode,
    // Comparator codes seen on the two CC pins
    output logic [1:0]      cc1_level,
    output logic [1:0]      cc2_level
);
    // Modes 1 to 4 are a sink on CC1 or CC2, with a marked cable in 2 and 4; 5 audio, 6 debug.
    assign cc1_level = (mode == 3'h1 || mode == 3'h2 || mode == 3'h6) ? typec_pkg::CC_RD :
                       (mode == 3'h4 || mode == 3'h5) ? typec_pkg::CC_RA : typec_pkg::CC_OPEN;
    assign cc2_level = (mode == 3'h3 || mode == 3'h4 || mode == 3'h6) ? typec_pkg::CC_RD :
                       (mode == 3'h2 || mode == 3'h5) ? typec_pkg::CC_RA : typec_pkg::CC_OPEN;
endmodule
`default_nettype wire

// *** sim/typec_source_port_control_checker.sv ***
// Concurrent checks on the pins of the Type-C source port control logic.
`timescale 1ns/100ps
`default_nettype none
module typec_source_port_control_checker #(
    parameter int DISCHARGE_CYC = typec_pkg::DISCHARGE_CYC,
    parameter int DEBOUNCE_CYC  = typec_pkg::DEBOUNCE_CYC
) (
    // Clock and reset
    input wire logic                        clk,
    input wire logic                        rst_n,
    // Inputs watched
    input wire logic                        enable,
    input wire logic                        switch_current_limiting,
    input wire logic                        switch_over_temp,
    // Outputs watched
    input wire logic                        bus_power_switch_on,
    input wire logic                        vbus_discharge_on,
    input wire logic                        cable_power_to_cc1,
    input wire logic                        cable_power_to_cc2,
    input wire logic                        current_limit_high,
    input wire logic [1:0]                  cc1_rp_level,
    input wire logic [1:0]                  cc2_rp_level,
    input wire logic [typec_pkg::OD_W-1:0]  status_pin_oe_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    int dis_cnt_q;
    always_ff @(posedge clk) begin
        if (!rst_n || !vbus_discharge_on) begin
            dis_cnt_q <= 0;
        end else begin
            dis_cnt_q <= dis_cnt_q + 1;
        end
    end
    a_vconn_single: assert property (!(cable_power_to_cc1 && cable_power_to_cc2))
        else $error("VCONN on both pins");
    a_vbus_with_sink: assert property (bus_power_switch_on |-> !status_pin_oe_n[typec_pkg::OD_SINK])
        else $error("VBUS on without sink flag");
    a_vconn_with_vbus: assert property ((cable_power_to_cc1 || cable_power_to_cc2) |-> bus_power_switch_on)
        else $error("VCONN without VBUS");
    a_vconn_cc1_side: assert property (cable_power_to_cc1 |-> !status_pin_oe_n[typec_pkg::OD_ORIENT])
        else $error("VCONN on CC1 with CC1 orientation");
    a_vconn_cc2_side: assert property (cable_power_to_cc2 |-> status_pin_oe_n[typec_pkg::OD_ORIENT])
        else $error("VCONN on CC2 with CC2 orientation");
    a_overload_set: assert property ((switch_current_limiting || switch_over_temp) [*3]
        |-> !status_pin_oe_n[typec_pkg::OD_OVERLOAD]) else $error("Overload pin not asserted");
    a_overload_clear: assert property (!(switch_current_limiting || switch_over_temp) [*3]
        |-> status_pin_oe_n[typec_pkg::OD_OVERLOAD]) else $error("Overload pin stuck");
    a_heavy_needs_3a: assert property (!status_pin_oe_n[typec_pkg::OD_HEAVY]
        |-> (cc1_rp_level == typec_pkg::RP_3A0 || cc2_rp_level == typec_pkg::RP_3A0))
        else $error("Heavy flag without 3A advertisement");
    a_disabled_unpowered: assert property (!enable [*4]
        |-> !bus_power_switch_on && !cable_power_to_cc1 && !cable_power_to_cc2) else $error("Power while disabled");
    a_discharge_quiet: assert property (vbus_discharge_on
        |-> !bus_power_switch_on && !cable_power_to_cc1 && !cable_power_to_cc2) else $error("Power during discharge");
    a_detach_discharge: assert property ($fell(bus_power_switch_on) |-> vbus_discharge_on)
        else $error("VBUS removed without discharge");
    a_discharge_length: assert property ($fell(vbus_discharge_on) |-> dis_cnt_q == DISCHARGE_CYC)
        else $error("Discharge length wrong");
    a_strap_steady: assert property ($past(rst_n, 3) && $past(rst_n, 2) && $past(rst_n)
        |-> $stable(current_limit_high)) else $error("Current limit level changed");
endmodule
bind typec_source_port_control typec_source_port_control_checker #(
    .DISCHARGE_CYC(DISCHARGE_CYC),
    .DEBOUNCE_CYC(DEBOUNCE_CYC)
) chk (.clk, .rst_n, .enable, .switch_current_limiting, .switch_over_temp, .bus_power_switch_on,
    .vbus_discharge_on, .cable_power_to_cc1, .cable_power_to_cc2, .current_limit_high, .cc1_rp_level,
    .cc2_rp_level, .status_pin_oe_n);
`default_nettype wire

// *** sim/typec_source_port_control_tb.sv ***
// Self-checking bench of the Type-C source port control logic.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
`define WAIT(c) begin n = 0; while (!(c) && n < 100) begin @(posedge clk); #1; n++; end \
    if (!(c)) begin failures++; end_sim(); end end
module typec_source_port_control_tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        enable = 1'b1;
    logic        charge_select = 1'b0;
    logic        charge_high_select = 1'b0;
    logic        current_limit_strap = 1'b0;
    logic        switch_current_limiting = 1'b0;
    logic        switch_over_temp = 1'b0;
    logic        load_above_heavy = 1'b0;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [2:0]  mode = 3'h0;
    logic [2:0]  st;
    logic [1:0]  cc1_level, cc2_level, cc1_rp_level, cc2_rp_level;
    logic        bus_power_switch_on, vbus_discharge_on, cable_power_to_cc1, cable_power_to_cc2;
    logic        current_limit_high, irq, sink;
    logic [5:0]  status_pin_in, status_pin_out, status_pin_oe_n;
    logic [31:0] reg_rdata, d;
    int          failures = 0;
    int          cmp_count = 0;
    int          n, m;

    always #25 clk = ~clk;
    // A pulled-up open-drain wire reads low only while some pin pulls it down.
    assign status_pin_in = status_pin_oe_n | status_pin_out;

    cc_partner far_end (.mode, .cc1_level, .cc2_level);
    typec_source_port_control #(.DISCHARGE_CYC(8), .DEBOUNCE_CYC(4)) DUT (.clk, .rst_n, .enable, .charge_select,
        .charge_high_select, .current_limit_strap, .cc1_level, .cc2_level, .switch_current_limiting,
        .switch_over_temp, .load_above_heavy, .bus_power_switch_on, .vbus_discharge_on, .cable_power_to_cc1,
        .cable_power_to_cc2, .current_limit_high, .cc1_rp_level, .cc2_rp_level, .status_pin_in, .status_pin_out,
        .status_pin_oe_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .irq);

    function automatic logic [1:0] adv(input logic c, input logic h);
        return !c ? typec_pkg::RP_DEFAULT : (h ? typec_pkg::RP_3A0 : typec_pkg::RP_1A5);
    endfunction

    task automatic end_sim();
        if (failures == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask

    initial begin
        void'($urandom(32'ha3b6));
        current_limit_strap <= 1'($urandom);
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        `CHK(current_limit_high, current_limit_strap)
        rd(typec_pkg::REG_CONTROL);
        `CHK(d, typec_pkg::CTRL_RESET)
        rd(typec_pkg::REG_IRQ_ENABLE);
        `CHK(d[3:0], typec_pkg::IRQ_ENABLE_RESET)
        rd(8'h20);
        `CHK(d, 32'h0)
        wr(typec_pkg::REG_IRQ_ENABLE, 32'h1);
        // A code held for less than the settling time must not count.
        @(posedge clk);
        mode <= 3'h1;
        repeat (2) @(posedge clk);
        mode <= 3'h0;
        repeat (8) @(posedge clk);
        #1;
        `CHK(status_pin_oe_n[0], 1'b1)
        for (m = 1; m <= 6; m++) begin
            @(posedge clk);
            mode <= 3'(m);
            // Corners: default current on mode 1, 1.5A on mode 3, 3A on mode 4.
            charge_select <= m == 4 || m == 3 || (m != 1 && 1'($urandom));
            charge_high_select <= m == 4 || (m != 3 && 1'($urandom));
            sink = (m <= 4);
            `WAIT(status_pin_oe_n[2:0] != 3'h7)
            st = sink ? 3'h1 : 3'(m - 3);
            `CHK(status_pin_oe_n[2:0], ~(3'h1 << (st - 3'h1)))
            `CHK(bus_power_switch_on, sink)
            `CHK(irq, 1'b1)
            if (sink) begin
                `CHK(status_pin_oe_n[3], m < 3)
                `CHK({cable_power_to_cc1, cable_power_to_cc2}, {m == 4, m == 2})
                `CHK(m < 3 ? cc1_rp_level : cc2_rp_level, adv(charge_select, charge_high_select))
                `CHK(m < 3 ? cc2_rp_level : cc1_rp_level, typec_pkg::RP_OFF)
                @(posedge clk);
                load_above_heavy <= 1'b1;
                switch_current_limiting <= m[0];
                switch_over_temp <= !m[0];
                repeat (3) @(posedge clk);
                #1;
                `CHK(status_pin_oe_n[5:4], {!(charge_select && charge_high_select), 1'b0})
                @(posedge clk);
                load_above_heavy <= 1'b0;
                switch_current_limiting <= 1'b0;
                switch_over_temp <= 1'b0;
            end
            wr(typec_pkg::REG_IRQ_CLEAR, 32'h1);
            @(posedge clk);
            #1;
            `CHK(irq, 1'b0)
            rd(typec_pkg::REG_PORT_STATE);
            `CHK({d[13:8], d[6:5], d[4] & sink, d[2:0]},
                 {status_pin_oe_n, current_limit_strap, m == 2 || m == 4, sink && m > 2, st})
            @(posedge clk);
            mode <= 3'h0;
            if (sink) begin
                `WAIT(vbus_discharge_on)
                `CHK({bus_power_switch_on, cable_power_to_cc1, cable_power_to_cc2}, 3'h0)
                `CHK(status_pin_oe_n, 6'h3f)
            end
            `WAIT(!vbus_discharge_on && status_pin_oe_n[2:0] == 3'h7 && cc1_rp_level != 2'h0 && cc2_rp_level != 2'h0)
            rd(typec_pkg::REG_STATUS);
            `CHK(d[3:0], {sink && charge_select && charge_high_select, sink, 2'h2})
            `CHK(irq, 1'b0)
            wr(typec_pkg::REG_IRQ_CLEAR, 32'hf);
        end
        @(posedge clk);
        mode <= 3'h2;
        `WAIT(bus_power_switch_on)
        @(posedge clk);
        enable <= 1'b0;
        `WAIT(vbus_discharge_on)
        `WAIT(!vbus_discharge_on)
        `CHK({bus_power_switch_on, cable_power_to_cc2, cc1_rp_level, cc2_rp_level}, 6'h0)
        @(posedge clk);
        mode <= 3'h0;
        enable <= 1'b1;
        `WAIT(cc1_rp_level != 2'h0)
        wr(typec_pkg::REG_CONTROL, 32'h0);
        @(posedge clk);
        mode <= 3'h3;
        repeat (20) @(posedge clk);
        #1;
        `CHK(status_pin_oe_n[0], 1'b1)
        wr(typec_pkg::REG_CONTROL, 32'h1);
        `WAIT(!status_pin_oe_n[0])
        `CHK(cc2_rp_level, adv(charge_select, charge_high_select))
        end_sim();
    end
endmodule
`default_nettype wire
